// ### include/pcpm_pkg.sv
// Constants, register map and types of the pump and compressor monitor.
package pcpm_pkg;
   // Supervision time base: one tick every 100 ms.
   localparam int TICK_NS = 100_000_000;
   // Clock rate in MHz.
   localparam int CLK_MHZ = 250;
   // Clock cycles per tick, derived from the time base and the rate.
   localparam int TICK_CYCLES = TICK_NS / 1000 * CLK_MHZ;
   // Ticks per second, used to scale whole-second settings.
   localparam logic [11:0] TICKS_PER_S = 12'h00A;
   // Percent scale used to turn whole percent into hundredths.
   localparam logic [15:0] PCT_SCALE = 16'h0064;
   // Divisor that applies a gain given in whole percent.
   localparam logic [31:0] GAIN_DIV = 32'h00000064;

   // Register byte offsets on the bus.
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLIM = 8'h04;
   localparam logic [7:0] ADDR_FTIME = 8'h08;
   localparam logic [7:0] ADDR_SUCT = 8'h0C;
   localparam logic [7:0] ADDR_DERATE = 8'h10;
   localparam logic [7:0] ADDR_OVLD = 8'h14;
   localparam logic [7:0] ADDR_TARGET = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_FLOW = 8'h20;
   localparam logic [7:0] ADDR_FREQ = 8'h24;

   // Reset value of every writable register.
   localparam logic [31:0] REG_RST = 32'h00000000;

   // Control register fields.
   localparam int CTRL_SRC_LSB = 0;
   localparam int CTRL_HVAC = 4;
   localparam int CTRL_PID_EN = 5;
   localparam int CTRL_PULSE = 6;
   localparam int CTRL_SUCT_LSB = 7;
   localparam int CTRL_REACT_LSB = 9;
   localparam int CTRL_SP_AIN = 11;
   localparam int CTRL_UNIT_LSB = 12;
   // Field positions shared by the packed setting registers.
   localparam int HI_LSB = 16;
   localparam int B1_LSB = 8;
   localparam int B2_LSB = 16;
   localparam int B3_LSB = 24;
   localparam int RESTORE_LSB = 8;

   // Main frequency source code that selects the PID path.
   localparam logic [3:0] MAIN_SRC_PID = 4'h5;
   // Low suction signal selection bits.
   localparam int SUCT_PID_BIT = 0;
   localparam int SUCT_CUR_BIT = 1;
   // Low suction reactions.
   localparam logic [1:0] REACT_WARN = 2'h1;
   localparam logic [1:0] REACT_FAULT = 2'h2;
   localparam logic [1:0] REACT_RESTART = 2'h3;
   // Restore cycles allowed before the derated frequency is held.
   localparam logic [2:0] RESTORE_MAX = 3'h3;

   // Derating state, Gray coded along normal, derated, locked.
   typedef enum logic [1:0] {
      DR_NORMAL = 2'b00,
      DR_DERATED = 2'b01,
      DR_LOCKED = 2'b11
   } pcpm_derate_e;

   // Warning and fault flags as seen by the keypad and software.
   typedef struct packed {
      logic ol_fault;
      logic ls_fault;
      logic ls_warn;
      logic lf_fault;
      logic lf_warn;
      logic hf_fault;
      logic hf_warn;
   } pcpm_stat_s;
endpackage

// ### rtl/pcpm_monitor.sv
// Pump and compressor protection monitor with its register slave.
//
// Summary of operation
// R1: Flow from analog or pulse input, readable.
// R2: High flow limit zero disables high supervision.
// R3: High flow dwell reaches warning time: warn.
// R4: High flow dwell reaches stop time: fault.
// R5: Low flow limit zero disables low supervision.
// R6: Low flow dwell reaches warning time: warn.
// R7: Low flow dwell reaches stop time: fault.
// R8: Suction select: off, PID, current, both.
// R9: Signal above level for detection time.
// R10: Suction reaction: none, warn, fault, restart.
// R11: Setpoint from flow target or analog one.
// R12: Display unit code passed to keypad.
// R13: Overcurrent at constant speed derates after delay.
// R14: Repeated delays compound the derating gain.
// R15: Current below level restores frequency.
// R16: After three restores, hold derated frequency.
// R17: Overload level for delay stops with fault.
// R18: Remote controller drops run to clear faults.
// R19: Operator picks keypad PID target source.
// R20: Flow functions only in HVAC PID mode.
// R21: Warning and stop timers share tick, clear together.
// R22: Restore counter clears when drive stops.
`timescale 1ns/1ps

// Dwell timer: counts ticks while a condition holds, clears when it drops.
module pcpm_dwell (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Condition, time base and limit in ticks.
   input wire logic i_cond,
   input wire logic i_tick,
   input wire logic [11:0] i_limit,
   // High while the condition has held for the limit.
   output logic o_hit
);
   logic [11:0] cnt_reg; // Ticks elapsed; saturates instead of wrapping.

   // Count only while the condition holds; any gap restarts it.
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_cond) begin
         cnt_reg <= 12'h000;
      end else if (i_tick && cnt_reg != 12'hFFF) begin
         cnt_reg <= cnt_reg + 12'h001;
      end
   end

   // Registered compare; a zero limit fires on the first cycle.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_hit <= 1'b0;
      end else begin
         o_hit <= i_cond && (cnt_reg >= i_limit);
      end
   end
endmodule

module pcpm_monitor #(
   // Cycles per supervision tick; shorten for simulation.
   parameter int TICK_CYCLES = pcpm_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input wire logic I_CLK,
   input wire logic I_RST,
   // AHB-Lite slave.
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // Process and drive signals, all on this clock.
   input wire logic [15:0] I_AIN_FLOW,
   input wire logic [15:0] I_PULSE_FLOW,
   input wire logic [15:0] I_AIN1_SP,
   input wire logic [15:0] I_PID_ERR,
   input wire logic [7:0] I_MOTOR_CUR,
   input wire logic [7:0] I_COMP_CUR,
   input wire logic [15:0] I_FREQ_CMD,
   input wire logic I_CONST_SPEED,
   input wire logic I_RUN,
   // Results to drive and keypad.
   output logic [15:0] O_FLOW,
   output logic [15:0] O_SETPOINT,
   output logic [15:0] O_FREQ_OUT,
   output logic [1:0] O_UNIT,
   output pcpm_pkg::pcpm_stat_s O_STAT,
   output logic O_FLASH,
   output logic O_STOP,
   output logic O_RESTART
);
   // Setting registers written by software.
   logic [31:0] ctrl_reg, flim_reg, ftime_reg, suct_reg;
   logic [31:0] derate_reg, ovld_reg, target_reg;
   // Bus data phase state.
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_next;
   // Time base.
   logic [24:0] tick_cnt_reg;
   logic tick_reg;
   // Flags, derating state and restore count.
   pcpm_pkg::pcpm_stat_s stat_reg;
   pcpm_pkg::pcpm_derate_e dr_reg;
   logic [2:0] restore_reg;
   logic [11:0] dr_cnt_reg;
   logic [15:0] freq_der_reg;
   logic [31:0] freq_prod;
   // Decoded conditions and dwell results.
   logic flow_act, hi_cond, lo_cond, ls_cond, ol_cond, over_lvl;
   logic hf_w, hf_s, lf_w, lf_s, ls_hit, ol_hit;
   logic pid_ok, cur_ok;
   logic [1:0] suct_sel, react;
   logic [15:0] flow_val, hi_lim, lo_lim;

   // Bus: the data phase of a write lands one cycle after the address.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
         wr_addr_reg <= I_HADDR[7:0];
      end
   end

   // The slave never stalls and never errors.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end
   end

   // Write data phase; unmapped offsets are ignored.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         ctrl_reg <= pcpm_pkg::REG_RST;
         flim_reg <= pcpm_pkg::REG_RST;
         ftime_reg <= pcpm_pkg::REG_RST;
         suct_reg <= pcpm_pkg::REG_RST;
         derate_reg <= pcpm_pkg::REG_RST;
         ovld_reg <= pcpm_pkg::REG_RST;
         target_reg <= pcpm_pkg::REG_RST;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            pcpm_pkg::ADDR_CTRL: ctrl_reg <= I_HWDATA;
            pcpm_pkg::ADDR_FLIM: flim_reg <= I_HWDATA;
            pcpm_pkg::ADDR_FTIME: ftime_reg <= I_HWDATA;
            pcpm_pkg::ADDR_SUCT: suct_reg <= I_HWDATA;
            pcpm_pkg::ADDR_DERATE: derate_reg <= I_HWDATA;
            pcpm_pkg::ADDR_OVLD: ovld_reg <= I_HWDATA;
            pcpm_pkg::ADDR_TARGET: target_reg <= I_HWDATA;
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Read mux during the address phase; unmapped offsets read zero.
   always_comb begin
      case (I_HADDR[7:0])
         pcpm_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
         pcpm_pkg::ADDR_FLIM: rdata_next = flim_reg;
         pcpm_pkg::ADDR_FTIME: rdata_next = ftime_reg;
         pcpm_pkg::ADDR_SUCT: rdata_next = suct_reg;
         pcpm_pkg::ADDR_DERATE: rdata_next = derate_reg;
         pcpm_pkg::ADDR_OVLD: rdata_next = ovld_reg;
         pcpm_pkg::ADDR_TARGET: rdata_next = target_reg;
         pcpm_pkg::ADDR_STATUS:
            rdata_next = {14'h0000, 3'(dr_reg), restore_reg, 5'h00,
               7'(stat_reg)};
         pcpm_pkg::ADDR_FLOW: rdata_next = {16'h0000, O_FLOW};
         pcpm_pkg::ADDR_FREQ: rdata_next = {16'h0000, O_FREQ_OUT};
         default: rdata_next = 32'h00000000;
      endcase
   end

   // Read data is registered so it stands during the data phase.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_HRDATA <= 32'h00000000;
      end else if (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE) begin
         O_HRDATA <= rdata_next;
      end
   end

   // 100 ms tick shared by every timer, so paired timers stay in step.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         tick_cnt_reg <= 25'h0000000;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == 25'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 25'h0000000;
         tick_reg <= 1'b1; // R21
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 25'h0000001;
         tick_reg <= 1'b0;
      end
   end

   // Flow decode: source select, activation and limit checks.
   always_comb begin
      flow_val = ctrl_reg[pcpm_pkg::CTRL_PULSE] ? I_PULSE_FLOW
         : I_AIN_FLOW; // R1
      flow_act = ctrl_reg[pcpm_pkg::CTRL_HVAC]
         && ctrl_reg[pcpm_pkg::CTRL_PID_EN]
         && ctrl_reg[pcpm_pkg::CTRL_SRC_LSB +: 4]
            == pcpm_pkg::MAIN_SRC_PID; // R20
      hi_lim = flim_reg[pcpm_pkg::HI_LSB +: 16];
      lo_lim = flim_reg[15:0];
      hi_cond = flow_act && hi_lim != 16'h0000 && flow_val > hi_lim; // R2
      lo_cond = flow_act && lo_lim != 16'h0000 && flow_val < lo_lim; // R5
   end

   // Suction, overload and derating level checks.
   always_comb begin
      suct_sel = ctrl_reg[pcpm_pkg::CTRL_SUCT_LSB +: 2];
      react = ctrl_reg[pcpm_pkg::CTRL_REACT_LSB +: 2];
      pid_ok = I_PID_ERR > 16'(suct_reg[pcpm_pkg::B2_LSB +: 8]
         * pcpm_pkg::PCT_SCALE);
      cur_ok = I_MOTOR_CUR > suct_reg[pcpm_pkg::B3_LSB +: 8];
      // Both selected signals must exceed their levels together.
      ls_cond = suct_sel != 2'h0
         && (!suct_sel[pcpm_pkg::SUCT_PID_BIT] || pid_ok)
         && (!suct_sel[pcpm_pkg::SUCT_CUR_BIT] || cur_ok); // R8
      ol_cond = I_COMP_CUR >= ovld_reg[7:0]; // R17
      over_lvl = I_COMP_CUR > derate_reg[7:0]; // R13
   end

   // Flow timers; warning and stop pairs share condition and tick.
   pcpm_dwell u_hf_warn (.i_clk(I_CLK), .i_rst(I_RST), .i_cond(hi_cond),
      .i_tick(tick_reg), .i_limit(12'(ftime_reg[7:0] * pcpm_pkg::TICKS_PER_S)),
      .o_hit(hf_w)); // R3
   pcpm_dwell u_hf_stop (.i_clk(I_CLK), .i_rst(I_RST), .i_cond(hi_cond),
      .i_tick(tick_reg),
      .i_limit(12'(ftime_reg[pcpm_pkg::B1_LSB +: 8] * pcpm_pkg::TICKS_PER_S)),
      .o_hit(hf_s)); // R4
   pcpm_dwell u_lf_warn (.i_clk(I_CLK), .i_rst(I_RST), .i_cond(lo_cond),
      .i_tick(tick_reg),
      .i_limit(12'(ftime_reg[pcpm_pkg::B2_LSB +: 8] * pcpm_pkg::TICKS_PER_S)),
      .o_hit(lf_w)); // R6
   pcpm_dwell u_lf_stop (.i_clk(I_CLK), .i_rst(I_RST), .i_cond(lo_cond),
      .i_tick(tick_reg),
      .i_limit(12'(ftime_reg[pcpm_pkg::B3_LSB +: 8] * pcpm_pkg::TICKS_PER_S)),
      .o_hit(lf_s)); // R7
   // Suction and overload delays are set in tenths of a second.
   pcpm_dwell u_ls (.i_clk(I_CLK), .i_rst(I_RST), .i_cond(ls_cond),
      .i_tick(tick_reg), .i_limit({2'b00, suct_reg[9:0]}),
      .o_hit(ls_hit)); // R9
   pcpm_dwell u_ol (.i_clk(I_CLK), .i_rst(I_RST), .i_cond(ol_cond),
      .i_tick(tick_reg), .i_limit({4'h0, ovld_reg[pcpm_pkg::B1_LSB +: 8]}),
      .o_hit(ol_hit)); // R17

   // Warnings follow their timers; faults other than a restart-reaction suction fault latch until run is dropped.
   // A new hit wins over the clear so no fault is lost.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         stat_reg <= '0;
      end else begin
         stat_reg.hf_warn <= hf_w; // R3
         stat_reg.lf_warn <= lf_w; // R6
         stat_reg.ls_warn <= ls_hit && react == pcpm_pkg::REACT_WARN; // R10
         stat_reg.hf_fault <= hf_s || (stat_reg.hf_fault && I_RUN); // R18
         stat_reg.lf_fault <= lf_s || (stat_reg.lf_fault && I_RUN); // R7
         stat_reg.ol_fault <= ol_hit || (stat_reg.ol_fault && I_RUN); // R17
         // Restart reaction clears itself once suction recovers.
         if (ls_hit && react[1]) begin
            stat_reg.ls_fault <= 1'b1; // R10
         end else if (!I_RUN || (react == pcpm_pkg::REACT_RESTART
               && stat_reg.ls_fault)) begin
            stat_reg.ls_fault <= 1'b0;
         end
      end
   end

   // Restart pulse when the restart reaction releases its fault.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_RESTART <= 1'b0;
      end else begin
         O_RESTART <= stat_reg.ls_fault && !ls_hit && I_RUN
            && react == pcpm_pkg::REACT_RESTART; // R10
      end
   end

   // Next compounded frequency; gain is whole percent.
   assign freq_prod = 32'(freq_der_reg) * 32'(derate_reg[pcpm_pkg::B2_LSB +: 7])
      / pcpm_pkg::GAIN_DIV;

   // Derating: each expired delay applies the gain once more; once the
   // restore count reaches its limit the last step is held, not compounded.
   always_ff @(posedge I_CLK) begin
      if (I_RST || !I_RUN) begin
         dr_reg <= pcpm_pkg::DR_NORMAL;
         restore_reg <= 3'h0; // R22
         dr_cnt_reg <= 12'h000;
         freq_der_reg <= 16'h0000;
      end else begin
         case (dr_reg)
            pcpm_pkg::DR_NORMAL: begin
               freq_der_reg <= I_FREQ_CMD;
               if (!(over_lvl && I_CONST_SPEED)) begin
                  dr_cnt_reg <= 12'h000;
               end else if (dr_cnt_reg >= {4'h0, derate_reg[15:8]}) begin
                  dr_cnt_reg <= 12'h000;
                  freq_der_reg <= 16'(32'(I_FREQ_CMD)
                     * 32'(derate_reg[pcpm_pkg::B2_LSB +: 7])
                     / pcpm_pkg::GAIN_DIV); // R13
                  dr_reg <= pcpm_pkg::DR_DERATED;
               end else if (tick_reg) begin
                  dr_cnt_reg <= dr_cnt_reg + 12'h001;
               end
            end
            pcpm_pkg::DR_DERATED: begin
               if (!over_lvl) begin
                  dr_cnt_reg <= 12'h000;
                  restore_reg <= restore_reg + 3'h1; // R15
                  dr_reg <= (restore_reg >= pcpm_pkg::RESTORE_MAX)
                     ? pcpm_pkg::DR_LOCKED : pcpm_pkg::DR_NORMAL; // R16
               end else if (dr_cnt_reg >= {4'h0, derate_reg[15:8]}) begin
                  dr_cnt_reg <= 12'h000;
                  freq_der_reg <= freq_prod[15:0]; // R14
               end else if (tick_reg) begin
                  dr_cnt_reg <= dr_cnt_reg + 12'h001;
               end
            end
            pcpm_pkg::DR_LOCKED: begin
               // Held at the last derated frequency until current drops.
               if (!over_lvl) begin
                  dr_reg <= pcpm_pkg::DR_NORMAL; // R16
               end
            end
            default: dr_reg <= pcpm_pkg::DR_NORMAL;
         endcase
      end
   end

   // Outputs to drive and keypad, each from a flip-flop.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_FLOW <= 16'h0000;
         O_SETPOINT <= 16'h0000;
         O_FREQ_OUT <= 16'h0000;
         O_UNIT <= 2'h0;
         O_STAT <= '0;
         O_STOP <= 1'b0;
      end else begin
         O_FLOW <= flow_val; // R1
         O_SETPOINT <= ctrl_reg[pcpm_pkg::CTRL_SP_AIN] ? I_AIN1_SP
            : target_reg[15:0]; // R11
         O_UNIT <= ctrl_reg[pcpm_pkg::CTRL_UNIT_LSB +: 2]; // R12
         O_FREQ_OUT <= (dr_reg == pcpm_pkg::DR_NORMAL) ? I_FREQ_CMD
            : freq_der_reg;
         O_STAT <= stat_reg;
         O_STOP <= stat_reg.hf_fault || stat_reg.lf_fault
            || stat_reg.ls_fault || stat_reg.ol_fault; // R4
      end
   end

   // Warnings blink at the tick rate so the keypad flashes them.
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_FLASH <= 1'b0;
      end else if (!(stat_reg.hf_warn || stat_reg.lf_warn
            || stat_reg.ls_warn)) begin
         O_FLASH <= 1'b0;
      end else if (tick_reg) begin
         O_FLASH <= !O_FLASH; // R3
      end
   end

   AST_HF_OFF: assert property (@(posedge I_CLK) disable iff (I_RST)
      flim_reg[31:16] == 16'h0000 |-> ##2 !hf_w) // R2
      else $error("high flow warning with limit zero");
   AST_LF_OFF: assert property (@(posedge I_CLK) disable iff (I_RST)
      !flow_act |-> ##2 !lf_w && !lf_s) // R20
      else $error("low flow timer ran while inactive");
   AST_HF_STOP: assert property (@(posedge I_CLK) disable iff (I_RST)
      hf_s |=> stat_reg.hf_fault ##1 O_STOP) // R4
      else $error("high flow stop did not stop drive");
   AST_PAIR_CLR: assert property (@(posedge I_CLK) disable iff (I_RST)
      !hi_cond |=> !hf_w && !hf_s) // R21
      else $error("flow timers did not clear together");
   AST_LS_WARN: assert property (@(posedge I_CLK) disable iff (I_RST)
      ls_hit && react == pcpm_pkg::REACT_WARN |=> stat_reg.ls_warn
      && !stat_reg.ls_fault) // R10
      else $error("low suction warning reaction wrong");
   AST_LS_SEL0: assert property (@(posedge I_CLK) disable iff (I_RST)
      suct_sel == 2'h0 |=> !ls_hit) // R8
      else $error("low suction seen with detection off");
   AST_OL: assert property (@(posedge I_CLK) disable iff (I_RST)
      ol_hit && I_RUN |=> stat_reg.ol_fault [*2]) // R17
      else $error("overload fault not latched");
   AST_RESTORE: assert property (@(posedge I_CLK) disable iff (I_RST)
      !I_RUN |=> restore_reg == 3'h0 && dr_reg == pcpm_pkg::DR_NORMAL) // R22
      else $error("restore count kept across stop");
   AST_LOCK: assert property (@(posedge I_CLK) disable iff (I_RST)
      dr_reg == pcpm_pkg::DR_LOCKED && over_lvl && I_RUN
      |=> $stable(freq_der_reg)) // R16
      else $error("locked frequency changed");
   AST_SP: assert property (@(posedge I_CLK) disable iff (I_RST)
      !ctrl_reg[pcpm_pkg::CTRL_SP_AIN] && $stable(target_reg)
      |=> O_SETPOINT == $past(target_reg[15:0])) // R11
      else $error("setpoint not from flow target");
endmodule

// ### verification/pcpm_plant.sv
// Behavioural motor, flow sensors and remote run controller.
`timescale 1ns/1ps
module pcpm_plant (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Bench process settings and the drive's stop.
   input wire logic i_req,
   input wire logic i_stop,
   input wire logic [15:0] i_flow,
   input wire logic [7:0] i_cur,
   // Sensor readings and run command.
   output logic [15:0] o_ain,
   output logic [15:0] o_pulse,
   output logic [7:0] o_cur,
   output logic o_run
);
   // Set by a stop; held until the controller drops its request.
   logic trip_reg;
   // Sensors lag by a cycle; the pulse meter reads one count high so
   // that the two flow paths can be told apart.
   always_ff @(posedge i_clk) begin
      o_ain <= i_flow;
      o_pulse <= i_flow + 16'h0001;
      o_cur <= i_cur;
   end
   // The remote controller must remove run to reset after a fault.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         trip_reg <= 1'b0;
      end else if (i_stop) begin
         trip_reg <= 1'b1;
      end else if (!i_req) begin
         trip_reg <= 1'b0;
      end
   end
   // Run is withdrawn at once on a stop, never re-raised by itself.
   assign o_run = i_req & ~trip_reg & ~i_stop;
endmodule

// ### verification/test_pcpm_monitor.sv
// Self-checking bench for the pump and compressor monitor.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
n_mismatch++; $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); \
end end
module test_pcpm_monitor;
   // Short tick keeps second-scale timers to tens of cycles.
   localparam int TK = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hrdata, rd, cw;
   logic hready, hresp, run, flash, stop, rstrt;
   logic spd = 1'b0, req = 1'b0, hwrite = 1'b0;
   logic [15:0] flow_set = 16'h1400, perr = 16'h0000;
   logic [15:0] ain, pls, flow, sp, fout;
   logic [7:0] cur_set = 8'h00, cur;
   logic [1:0] unit;
   pcpm_pkg::pcpm_stat_s stat;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n;
   // Clock of 4 ns period.
   always #2 clk = ~clk;
   pcpm_plant u_plant (.i_clk(clk), .i_rst(rst), .i_req(req), .i_stop(stop),
      .i_flow(flow_set), .i_cur(cur_set), .o_ain(ain), .o_pulse(pls),
      .o_cur(cur), .o_run(run));
   pcpm_monitor #(.TICK_CYCLES(TK)) u_dut (.I_CLK(clk), .I_RST(rst),
      .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_AIN_FLOW(ain), .I_PULSE_FLOW(pls), .I_AIN1_SP(16'h0ABC),
      .I_PID_ERR(perr), .I_MOTOR_CUR(cur), .I_COMP_CUR(cur),
      .I_FREQ_CMD(16'h03E8), .I_CONST_SPEED(spd), .I_RUN(run),
      .O_FLOW(flow), .O_SETPOINT(sp), .O_FREQ_OUT(fout), .O_UNIT(unit),
      .O_STAT(stat), .O_FLASH(flash), .O_STOP(stop), .O_RESTART(rstrt));
   // One single-word transfer; each phase is held until hready is seen.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
      `CHK({hresp, hready}, 2'b01)
   endtask
   // Waits for a masked flag, counting cycles.
   task automatic wait_stat(input logic [6:0] m);
      n = 0;
      while ((stat & m) === 7'h00 && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Waits for the output frequency to change.
   task automatic wait_fout(input logic [15:0] old);
      n = 0;
      while (fout === old && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Drops run so latched faults clear, then runs again.
   task automatic rearm();
      req <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(stop, 1'b0)
      req <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // A short return to normal flow must restart both timers; then the
   // warning and the fault follow one and two seconds later.
   task automatic flow_case(input logic [31:0] lim, input logic [31:0] tm,
      input logic [15:0] bad, input logic [6:0] wm, input logic [6:0] fm);
      xfer(1'b1, pcpm_pkg::ADDR_FLIM, lim);
      xfer(1'b1, pcpm_pkg::ADDR_FTIME, tm);
      flow_set <= bad;
      repeat (30) @(posedge clk);
      flow_set <= 16'h1400;
      repeat (4) @(posedge clk);
      flow_set <= bad;
      wait_stat(wm);
      `CHK(n >= 10 * TK - 4 && n <= 10 * TK + 8, 1'b1)
      `CHK(stat & fm, 7'h00)
      rd[0] = flash;
      repeat (TK) @(posedge clk);
      `CHK(flash, !rd[0])
      wait_stat(fm);
      `CHK(n >= 10 * TK - 8 && n <= 10 * TK + 8, 1'b1)
      repeat (3) @(posedge clk);
      `CHK(stop, 1'b1)
      flow_set <= 16'h1400;
      rearm();
      `CHK(stat, 7'h00)
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog at 50,000 cycles, far beyond the roughly 1,250 cycles needed.
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Overload out of reach before anything runs.
      xfer(1'b1, pcpm_pkg::ADDR_OVLD, 32'h000000C8);
      // Reset values, a read-only write and an unmapped address.
      xfer(1'b0, pcpm_pkg::ADDR_FLIM, 32'h0);
      `CHK(rd, pcpm_pkg::REG_RST)
      xfer(1'b1, pcpm_pkg::ADDR_STATUS, 32'hFFFFFFFF);
      xfer(1'b0, pcpm_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h00000000)
      xfer(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h00000000)
      // The PID target is taken from the keypad for this setpoint.
      xfer(1'b1, pcpm_pkg::ADDR_TARGET, 32'h00000777);
      // Flow source, setpoint source and display unit in every code.
      for (int u = 0; u < 4; u++) begin
         cw = 32'h35 | (32'(u) << 12) | (32'(u & 1) << 6) | (32'(u / 2) << 11);
         xfer(1'b1, pcpm_pkg::ADDR_CTRL, cw);
         repeat (4) @(posedge clk);
         `CHK(unit, 2'(u))
         `CHK(flow, (u & 1) ? 16'h1401 : 16'h1400)
         `CHK(sp, (u >= 2) ? 16'h0ABC : 16'h0777)
         xfer(1'b0, pcpm_pkg::ADDR_FLOW, 32'h0);
         `CHK(rd[15:0], (u & 1) ? 16'h1401 : 16'h1400)
         xfer(1'b0, pcpm_pkg::ADDR_CTRL, 32'h0);
         `CHK(rd, cw)
      end
      req <= 1'b1;
      // No flow supervision outside PID source, nor with zero limits.
      xfer(1'b1, pcpm_pkg::ADDR_CTRL, 32'h00000034);
      xfer(1'b1, pcpm_pkg::ADDR_FLIM, 32'h18001000);
      xfer(1'b1, pcpm_pkg::ADDR_FTIME, 32'h02010201);
      flow_set <= 16'h2000;
      repeat (120) @(posedge clk);
      `CHK(stat, 7'h00)
      xfer(1'b1, pcpm_pkg::ADDR_CTRL, 32'h00000035);
      xfer(1'b1, pcpm_pkg::ADDR_FLIM, 32'h00000000);
      repeat (120) @(posedge clk);
      `CHK(stat, 7'h00)
      flow_set <= 16'h0800;
      repeat (120) @(posedge clk);
      `CHK(stat, 7'h00)
      flow_set <= 16'h1400;
      // High then low excursions with warning 1 s and stop 2 s.
      flow_case(32'h18000000, 32'h00000201, 16'h2000, 7'h01, 7'h02);
      flow_case(32'h00001000, 32'h02010000, 16'h0800, 7'h04, 7'h08);
      xfer(1'b1, pcpm_pkg::ADDR_FLIM, 32'h0);
      // Suction source: PID error 40 % against level 30 %, current low.
      xfer(1'b1, pcpm_pkg::ADDR_SUCT, 32'h3C1E0002);
      perr <= 16'h0FA0;
      for (int s = 0; s < 3; s++) begin
         xfer(1'b1, pcpm_pkg::ADDR_CTRL, 32'h235 | (32'(s) << 7));
         repeat (40) @(posedge clk);
         `CHK(stat.ls_warn, s == 1)
         perr <= 16'h0000;
         repeat (8) @(posedge clk);
         perr <= 16'h0FA0;
      end
      perr <= 16'h0000;
      // Every reaction to low suction detected on current 80 % > 60 %.
      for (int r = 0; r < 4; r++) begin
         xfer(1'b1, pcpm_pkg::ADDR_CTRL, 32'h135 | (32'(r) << 9));
         cur_set <= 8'h50;
         repeat (40) @(posedge clk);
         `CHK(stat.ls_warn, r == 1)
         `CHK(stat.ls_fault, r >= 2)
         `CHK(stop, r >= 2)
         `CHK(rstrt, 1'b0)
         cur_set <= 8'h00;
         rearm();
      end
      // Derating: gain 90 %, delay 1 s, level 50 %, compounding.
      xfer(1'b1, pcpm_pkg::ADDR_CTRL, 32'h00000035);
      xfer(1'b1, pcpm_pkg::ADDR_DERATE, 32'h005A0A32);
      `CHK(fout, 16'h03E8)
      spd <= 1'b1;
      cur_set <= 8'h50;
      wait_fout(16'h03E8);
      `CHK(fout, 16'h0384)
      xfer(1'b0, pcpm_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[16:15], pcpm_pkg::DR_DERATED)
      wait_fout(16'h0384);
      `CHK(fout, 16'h032A)
      cur_set <= 8'h14;
      wait_fout(16'h032A);
      `CHK(fout, 16'h03E8)
      spd <= 1'b0;
      rearm();
      // Overload: current exactly at 70 % for 0.5 s stops the drive.
      xfer(1'b1, pcpm_pkg::ADDR_OVLD, 32'h00000546);
      cur_set <= 8'h46;
      wait_stat(7'h40);
      `CHK(n >= 5 * TK - 4 && n <= 5 * TK + 8, 1'b1)
      repeat (3) @(posedge clk);
      `CHK(stop, 1'b1)
      cur_set <= 8'h00;
      rearm();
      print_verdict();
   end
endmodule
